// ==== hw/fesac_bank.sv ====
// error flags, drive strength, function, protection config and boot-on-select bank
module fesac_bank #(
	parameter logic [7:0] FUNC_OTP_MASK    = 8'hF0,
	parameter logic [7:0] FUNC_RO_MASK     = 8'h01,
	parameter logic [7:0] FUNC_FREEZE_MASK = 8'h0E
) (
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	input  wire fesac_pkg::fesac_cmd_event_type cmd_event,
	input  wire logic                          sck,
	input  wire logic                          cs_n,
	output logic      [2:0]                    drive_strength,
	output logic      [2:0]                    error_flags,
	output logic                               quad_enable,
	output fesac_pkg::fesac_boot_type          boot
);

	// ==================================================
	// parameter checks
	if ((FUNC_OTP_MASK & FUNC_RO_MASK) != 8'h00 || (FUNC_OTP_MASK & FUNC_FREEZE_MASK) != 8'h00
		|| (FUNC_RO_MASK & FUNC_FREEZE_MASK) != 8'h00) begin : g_bad_masks
		$error("function register masks must not overlap");
	end

	// ==================================================
	// state
	typedef struct packed {
		logic                            sck_meta;
		logic                            sck_sync;
		logic                            sck_prev;
		logic                            cs_meta;
		logic                            cs_sync;
		logic                            cs_prev;
		logic                            wr_pend;
		logic [7:0]                      wr_addr;
		logic [31:0]                     rdata;
		logic                            resp;
		logic                            ready;
		logic                            err_prot;
		logic                            err_prog;
		logic                            err_erase;
		logic [2:0]                      ds;
		logic [31:0]                     boot_cfg;
		logic                            qe;
		logic                            freeze;
		logic [7:0]                      func;
		logic [15:0]                     prot_cfg;
		fesac_pkg::fesac_boot_state_type boot_state;
		logic [4:0]                      delay_cnt;
		logic                            boot_active;
		logic                            boot_start;
		logic [31:0]                     boot_addr;
	} fesac_state_type;

	localparam fesac_state_type STATE_RESET = '{
		sck_meta:    1'b0,
		sck_sync:    1'b0,
		sck_prev:    1'b0,
		cs_meta:     1'b1,
		cs_sync:     1'b1,
		cs_prev:     1'b1,
		wr_pend:     1'b0,
		wr_addr:     8'h00,
		rdata:       32'h0000_0000,
		resp:        1'b0,
		ready:       1'b1,
		err_prot:    1'b0,
		err_prog:    1'b0,
		err_erase:   1'b0,
		ds:          fesac_pkg::DS_RESET,
		boot_cfg:    fesac_pkg::BOOT_CFG_RESET,
		qe:          1'b0,
		freeze:      1'b0,
		func:        fesac_pkg::FUNC_RESET,
		prot_cfg:    fesac_pkg::PROT_CFG_RESET,
		boot_state:  fesac_pkg::BOOT_IDLE,
		delay_cnt:   5'h00,
		boot_active: 1'b0,
		boot_start:  1'b0,
		boot_addr:   32'h0000_0000
	};

	fesac_state_type state_ff;
	fesac_state_type nxt_state;

	// ==================================================
	// helpers
	function automatic logic ds_code_legal(input logic [2:0] code);
		ds_code_legal = (code != fesac_pkg::DS_RSVD_A) && (code != fesac_pkg::DS_RSVD_B);
	endfunction : ds_code_legal

	function automatic logic [31:0] read_word(input fesac_state_type s, input logic [7:0] addr);
		read_word = 32'h0000_0000;
		unique case (addr)
			fesac_pkg::ADDR_EXT_READ: begin
				read_word[fesac_pkg::DS_MSB:fesac_pkg::DS_LSB] = s.ds;
				read_word[fesac_pkg::ERR_PROT_BIT]             = s.err_prot;
				read_word[fesac_pkg::ERR_PROG_BIT]             = s.err_prog;
				read_word[fesac_pkg::ERR_ERASE_BIT]            = s.err_erase;
			end
			fesac_pkg::ADDR_BOOT_CFG: begin
				read_word = s.boot_cfg;
			end
			fesac_pkg::ADDR_CONTROL: begin
				read_word[fesac_pkg::CTRL_QE_BIT]     = s.qe;
				read_word[fesac_pkg::CTRL_FREEZE_BIT] = s.freeze;
			end
			fesac_pkg::ADDR_FUNC: begin
				read_word[7:0] = s.func;
			end
			fesac_pkg::ADDR_PROT_CFG: begin
				read_word[15:0] = s.prot_cfg;
			end
			default: begin
				read_word = 32'h0000_0000;
			end
		endcase
	endfunction : read_word

	// ==================================================
	// next state
	logic       set_prot;
	logic       set_prog;
	logic       set_erase;
	logic       clr_err;
	logic       addr_phase;
	logic       sck_rise;
	logic       cs_fall;
	logic       cs_rise;
	logic [4:0] boot_delay;
	logic [1:0] lock_req;
	logic [7:0] func_wr_mask;

	always_comb begin
		nxt_state  = state_ff;
		set_prot   = 1'b0;
		set_prog   = 1'b0;
		set_erase  = 1'b0;
		clr_err    = 1'b0;
		lock_req   = cmd_event.data[fesac_pkg::PROT_LOCK_MSB:fesac_pkg::PROT_LOCK_LSB];
		func_wr_mask = ~FUNC_RO_MASK & ~(state_ff.freeze ? FUNC_FREEZE_MASK : 8'h00);

		// pin synchronisers
		nxt_state.sck_meta = sck;
		nxt_state.sck_sync = state_ff.sck_meta;
		nxt_state.sck_prev = state_ff.sck_sync;
		nxt_state.cs_meta  = cs_n;
		nxt_state.cs_sync  = state_ff.cs_meta;
		nxt_state.cs_prev  = state_ff.cs_sync;
		sck_rise = state_ff.sck_sync & ~state_ff.sck_prev;
		cs_fall  = ~state_ff.cs_sync & state_ff.cs_prev;
		cs_rise  = state_ff.cs_sync & ~state_ff.cs_prev;

		// bus slave: zero wait states, always OKAY
		nxt_state.ready = 1'b1;
		nxt_state.resp  = 1'b0;
		addr_phase = hsel & htrans[1] & hready;
		if (state_ff.wr_pend) begin
			unique case (state_ff.wr_addr)
				fesac_pkg::ADDR_EXT_READ: begin
					// error bits in the written word are dropped
					if (ds_code_legal(hwdata[fesac_pkg::DS_MSB:fesac_pkg::DS_LSB])) begin
						nxt_state.ds = hwdata[fesac_pkg::DS_MSB:fesac_pkg::DS_LSB];
					end
				end
				fesac_pkg::ADDR_BOOT_CFG: begin
					nxt_state.boot_cfg = hwdata;
				end
				fesac_pkg::ADDR_CONTROL: begin
					clr_err          = hwdata[fesac_pkg::CTRL_CLEAR_BIT];
					nxt_state.qe     = hwdata[fesac_pkg::CTRL_QE_BIT];
					nxt_state.freeze = hwdata[fesac_pkg::CTRL_FREEZE_BIT];
				end
				default: begin
				end
			endcase
		end
		nxt_state.wr_pend = addr_phase & hwrite;
		nxt_state.wr_addr = haddr[7:0];
		if (addr_phase && !hwrite) begin
			nxt_state.rdata = read_word(state_ff, haddr[7:0]);
		end

		// command outcomes; nothing here gates a later command on the flags
		if (cmd_event.valid) begin
			unique case (cmd_event.kind)
				fesac_pkg::CMD_PAGE_PROG: begin
					set_prog = cmd_event.fail_program;
					if (cmd_event.target_protected || cmd_event.target_suspended) begin
						set_prog = 1'b1;
						set_prot = 1'b1;
					end
				end
				fesac_pkg::CMD_INFO_PROG: begin
					set_prog = cmd_event.fail_program;
					if (cmd_event.info_row_locked) begin
						set_prog = 1'b1;
						set_prot = 1'b1;
					end
				end
				fesac_pkg::CMD_PROT_PROG: begin
					if ((state_ff.prot_cfg[fesac_pkg::PROT_LOCK_MSB:fesac_pkg::PROT_LOCK_LSB]
						!= fesac_pkg::LOCK_NONE && lock_req != fesac_pkg::LOCK_NONE)
						|| lock_req == fesac_pkg::LOCK_BOTH) begin
						set_prog = 1'b1;
						set_prot = 1'b1;
					end else if (cmd_event.fail_program) begin
						set_prog = 1'b1;
					end else begin
						// lock bits only clear, parameter location bit only sets
						nxt_state.prot_cfg[fesac_pkg::PROT_LOCK_MSB:fesac_pkg::PROT_LOCK_LSB] =
							state_ff.prot_cfg[fesac_pkg::PROT_LOCK_MSB:fesac_pkg::PROT_LOCK_LSB]
							& lock_req;
						nxt_state.prot_cfg[fesac_pkg::PROT_PARAM_BIT] =
							state_ff.prot_cfg[fesac_pkg::PROT_PARAM_BIT]
							| cmd_event.data[fesac_pkg::PROT_PARAM_BIT];
					end
				end
				fesac_pkg::CMD_PWD_UNLOCK: begin
					set_prog = cmd_event.fail_program;
					if (cmd_event.pwd_mismatch) begin
						set_prog = 1'b1;
						set_prot = 1'b1;
					end
				end
				fesac_pkg::CMD_NV_WRITE: begin
					set_erase = cmd_event.fail_erase;
					set_prog  = cmd_event.fail_program;
				end
				fesac_pkg::CMD_STATUS_WR: begin
					if (cmd_event.status_reg_locked) begin
						set_prot  = 1'b1;
						set_erase = 1'b1;
					end else begin
						set_erase = cmd_event.fail_erase;
						set_prog  = cmd_event.fail_program;
					end
				end
				fesac_pkg::CMD_EXT_SET: begin
					set_erase = cmd_event.fail_erase;
					set_prog  = cmd_event.fail_program;
					// only the strength field moves; flag bits of the data are dropped
					if (!cmd_event.fail_erase && !cmd_event.fail_program
						&& ds_code_legal(cmd_event.data[fesac_pkg::DS_MSB:fesac_pkg::DS_LSB])) begin
						nxt_state.ds = cmd_event.data[fesac_pkg::DS_MSB:fesac_pkg::DS_LSB];
					end
				end
				fesac_pkg::CMD_FUNC_WR: begin
					set_prog = cmd_event.fail_program;
					if (!cmd_event.fail_program) begin
						nxt_state.func = (state_ff.func & ~func_wr_mask)
							| (cmd_event.data[7:0] & func_wr_mask & ~FUNC_OTP_MASK)
							| ((state_ff.func | cmd_event.data[7:0])
								& func_wr_mask & FUNC_OTP_MASK);
					end
				end
				fesac_pkg::CMD_ERASE: begin
					set_erase = cmd_event.fail_erase;
					if (cmd_event.target_protected || cmd_event.info_row_locked) begin
						set_erase = 1'b1;
						set_prot  = 1'b1;
					end
				end
				fesac_pkg::CMD_CHIP_ERASE: begin
					set_erase = cmd_event.fail_erase;
					// sectors held only by dynamic or persistent bits are not errors here
					if (cmd_event.block_protect_hit) begin
						set_erase = 1'b1;
						set_prot  = 1'b1;
					end
				end
				fesac_pkg::CMD_CLEAR_ERR, fesac_pkg::CMD_SOFT_RESET: begin
					clr_err = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// sticky flags; a set in the clearing cycle survives
		nxt_state.err_prot  = (state_ff.err_prot & ~clr_err) | set_prot;
		nxt_state.err_prog  = (state_ff.err_prog & ~clr_err) | set_prog;
		nxt_state.err_erase = (state_ff.err_erase & ~clr_err) | set_erase;

		// boot-on-select: delay counted in link clock rising edges
		boot_delay = {1'b0, state_ff.boot_cfg[fesac_pkg::BOOT_DELAY_MSB:fesac_pkg::BOOT_DELAY_LSB]};
		if (boot_delay == 5'h00) begin
			boot_delay = {1'b0, state_ff.qe ? fesac_pkg::DUMMY_QUAD : fesac_pkg::DUMMY_SPI};
		end
		nxt_state.boot_start = 1'b0;
		unique case (state_ff.boot_state)
			fesac_pkg::BOOT_IDLE: begin
				nxt_state.delay_cnt = 5'h00;
				if (cs_fall && state_ff.boot_cfg[fesac_pkg::BOOT_EN_BIT]) begin
					nxt_state.boot_state = fesac_pkg::BOOT_DELAY;
				end
			end
			fesac_pkg::BOOT_DELAY: begin
				if (cs_rise) begin
					nxt_state.boot_state = fesac_pkg::BOOT_IDLE;
				end else if (sck_rise) begin
					nxt_state.delay_cnt = state_ff.delay_cnt + 5'h01;
					if (state_ff.delay_cnt + 5'h01 == boot_delay) begin
						nxt_state.boot_state  = fesac_pkg::BOOT_STREAM;
						nxt_state.boot_active = 1'b1;
						nxt_state.boot_start  = 1'b1;
						nxt_state.boot_addr   = {state_ff.boot_cfg[31:fesac_pkg::BOOT_ADDR_LSB],
							5'h00};
					end
				end
			end
			fesac_pkg::BOOT_STREAM: begin
				if (cs_rise) begin
					nxt_state.boot_state  = fesac_pkg::BOOT_IDLE;
					nxt_state.boot_active = 1'b0;
				end
			end
			default: begin
				nxt_state.boot_state  = fesac_pkg::BOOT_IDLE;
				nxt_state.boot_active = 1'b0;
			end
		endcase
	end

	// ==================================================
	// registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= STATE_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==================================================
	// outputs
	assign hrdata         = state_ff.rdata;
	assign hreadyout      = state_ff.ready;
	assign hresp          = state_ff.resp;
	assign drive_strength = state_ff.ds;
	assign error_flags    = {state_ff.err_erase, state_ff.err_prog, state_ff.err_prot};
	assign quad_enable    = state_ff.qe;
	assign boot.active    = state_ff.boot_active;
	assign boot.start     = state_ff.boot_start;
	assign boot.addr      = state_ff.boot_addr;

endmodule : fesac_bank

// ==== inc/fesac_pkg.sv ====
// constants, field layouts and carrier types of the flash error status and boot config bank
// ==========================================================================================
package fesac_pkg;

	// ==================================================
	// register offsets
	localparam logic [7:0] ADDR_EXT_READ  = 8'h00;
	localparam logic [7:0] ADDR_BOOT_CFG  = 8'h04;
	localparam logic [7:0] ADDR_CONTROL   = 8'h08;
	localparam logic [7:0] ADDR_FUNC      = 8'h0C;
	localparam logic [7:0] ADDR_PROT_CFG  = 8'h10;

	// ==================================================
	// field positions
	localparam int DS_LSB           = 5;
	localparam int DS_MSB           = 7;
	localparam int ERR_PROT_BIT     = 1;
	localparam int ERR_PROG_BIT     = 2;
	localparam int ERR_ERASE_BIT    = 3;
	localparam int BOOT_ADDR_LSB    = 5;
	localparam int BOOT_DELAY_LSB   = 1;
	localparam int BOOT_DELAY_MSB   = 4;
	localparam int BOOT_EN_BIT      = 0;
	localparam int CTRL_CLEAR_BIT   = 0;
	localparam int CTRL_QE_BIT      = 1;
	localparam int CTRL_FREEZE_BIT  = 2;
	localparam int PROT_LOCK_LSB    = 1;
	localparam int PROT_LOCK_MSB    = 2;
	localparam int PROT_PARAM_BIT   = 15;

	// ==================================================
	// reset values and codes
	localparam logic [2:0]  DS_RESET        = 3'h7;
	localparam logic [2:0]  DS_RSVD_A       = 3'h0;
	localparam logic [2:0]  DS_RSVD_B       = 3'h4;
	localparam logic [31:0] BOOT_CFG_RESET  = 32'h0000_0000;
	localparam logic [15:0] PROT_CFG_RESET  = 16'hFFFF;
	localparam logic [7:0]  FUNC_RESET      = 8'h00;
	localparam logic [1:0]  LOCK_NONE       = 2'h3;
	localparam logic [1:0]  LOCK_BOTH       = 2'h0;
	localparam logic [3:0]  DUMMY_SPI       = 4'h8;
	localparam logic [3:0]  DUMMY_QUAD      = 4'h6;

	// ==================================================
	// command kinds reported by the command engine
	typedef enum logic [3:0] {
		CMD_NONE        = 4'b0000,
		CMD_PAGE_PROG   = 4'b0001,
		CMD_INFO_PROG   = 4'b0010,
		CMD_PROT_PROG   = 4'b0011,
		CMD_PWD_UNLOCK  = 4'b0100,
		CMD_NV_WRITE    = 4'b0101,
		CMD_STATUS_WR   = 4'b0110,
		CMD_EXT_SET     = 4'b0111,
		CMD_FUNC_WR     = 4'b1000,
		CMD_ERASE       = 4'b1001,
		CMD_CHIP_ERASE  = 4'b1010,
		CMD_CLEAR_ERR   = 4'b1011,
		CMD_SOFT_RESET  = 4'b1100
	} fesac_cmd_kind_type;

	typedef enum logic [1:0] {
		BOOT_IDLE   = 2'b00,
		BOOT_DELAY  = 2'b01,
		BOOT_STREAM = 2'b10
	} fesac_boot_state_type;

	// one finished command with its outcome
	typedef struct packed {
		logic               valid;
		fesac_cmd_kind_type kind;
		logic [15:0]        data;
		logic               fail_program;
		logic               fail_erase;
		logic               target_protected;
		logic               target_suspended;
		logic               info_row_locked;
		logic               block_protect_hit;
		logic               pwd_mismatch;
		logic               status_reg_locked;
	} fesac_cmd_event_type;

	typedef struct packed {
		logic        active;
		logic        start;
		logic [31:0] addr;
	} fesac_boot_type;

endpackage : fesac_pkg

// ==== dv/fesac_bank_sva.sv ====
// assertion checker for the flash error status and boot config bank
module fesac_bank_sva (
	input wire logic                           clk,
	input wire logic                           reset,
	input wire logic                           hsel,
	input wire logic [31:0]                    haddr,
	input wire logic [1:0]                     htrans,
	input wire logic                           hwrite,
	input wire logic [2:0]                     hsize,
	input wire logic [31:0]                    hwdata,
	input wire logic                           hready,
	input wire logic [31:0]                    hrdata,
	input wire logic                           hreadyout,
	input wire logic                           hresp,
	input wire fesac_pkg::fesac_cmd_event_type cmd_event,
	input wire logic                           sck,
	input wire logic                           cs_n,
	input wire logic [2:0]                     drive_strength,
	input wire logic [2:0]                     error_flags,
	input wire logic                           quad_enable,
	input wire fesac_pkg::fesac_boot_type      boot
);
	// ==========================================
	// helper logic
	logic                          wr_ctl_ff;
	logic                          clr;
	logic                          ev;
	logic [2:0]                    ds_req;
	fesac_pkg::fesac_cmd_kind_type k;

	assign ev     = cmd_event.valid;
	assign k      = cmd_event.kind;
	assign ds_req = cmd_event.data[7:5];
	// a bus clear lands one cycle after its address phase, so track the data phase
	assign clr = (wr_ctl_ff & hwdata[fesac_pkg::CTRL_CLEAR_BIT])
		| (ev & (k == fesac_pkg::CMD_CLEAR_ERR || k == fesac_pkg::CMD_SOFT_RESET));

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ctl_ff <= 1'h0;
		end else begin
			wr_ctl_ff <= hsel & htrans[1] & hready & hwrite
				& (haddr[7:0] == fesac_pkg::ADDR_CONTROL);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// ==========================================
	// flag setting
	sequence s_prog_prot;
		ev && ((k == fesac_pkg::CMD_PAGE_PROG
			&& (cmd_event.target_protected || cmd_event.target_suspended))
			|| (k == fesac_pkg::CMD_INFO_PROG && cmd_event.info_row_locked)
			|| (k == fesac_pkg::CMD_PWD_UNLOCK && cmd_event.pwd_mismatch));
	endsequence
	sequence s_erase_prot;
		ev && ((k == fesac_pkg::CMD_ERASE
			&& (cmd_event.target_protected || cmd_event.info_row_locked))
			|| (k == fesac_pkg::CMD_CHIP_ERASE && cmd_event.block_protect_hit)
			|| (k == fesac_pkg::CMD_STATUS_WR && cmd_event.status_reg_locked));
	endsequence
	property p_prog_prot;
		s_prog_prot |=> error_flags[1:0] == 2'h3;
	endproperty
	a_prog_prot: assert property (p_prog_prot)
		else $error("program and protection flags missing");
	property p_erase_prot;
		s_erase_prot |=> error_flags[2] && error_flags[0];
	endproperty
	a_erase_prot: assert property (p_erase_prot)
		else $error("erase and protection flags missing");
	property p_nv_fail;
		ev && k == fesac_pkg::CMD_NV_WRITE |=> (error_flags[2] || !$past(cmd_event.fail_erase))
			&& (error_flags[1] || !$past(cmd_event.fail_program));
	endproperty
	a_nv_fail: assert property (p_nv_fail)
		else $error("register write failure not flagged");
	property p_chip_asp;
		ev && k == fesac_pkg::CMD_CHIP_ERASE && !cmd_event.block_protect_hit
			&& !cmd_event.fail_erase && !clr |=> $stable(error_flags);
	endproperty
	a_chip_asp: assert property (p_chip_asp)
		else $error("chip erase flagged without block hit");
	property p_sticky;
		(|($past(error_flags) & ~error_flags)) && !$past(reset) |-> $past(clr);
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag dropped without a clear");

	// ==========================================
	// drive strength and boot
	property p_ds_set;
		ev && k == fesac_pkg::CMD_EXT_SET && !cmd_event.fail_erase && !cmd_event.fail_program
			&& ds_req != fesac_pkg::DS_RSVD_A && ds_req != fesac_pkg::DS_RSVD_B
			|=> drive_strength == $past(ds_req);
	endproperty
	a_ds_set: assert property (p_ds_set) else $error("drive strength not taken");
	property p_boot_start;
		boot.start |-> boot.active && boot.addr[4:0] == 5'h0;
	endproperty
	a_boot_start: assert property (p_boot_start) else $error("boot start badly formed");
	property p_boot_end;
		cs_n [*5] |-> !boot.active;
	endproperty
	a_boot_end: assert property (p_boot_end) else $error("boot stream outlives select");
endmodule : fesac_bank_sva

bind fesac_bank fesac_bank_sva fesac_bank_sva_inst (
	.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .cmd_event(cmd_event), .sck(sck), .cs_n(cs_n),
	.drive_strength(drive_strength), .error_flags(error_flags), .quad_enable(quad_enable),
	.boot(boot)
);

// ==== dv/fesac_host_model.sv ====
// host serial controller model: frames chip select and the serial clock
module fesac_host_model (
	output logic sck,
	output logic cs_n
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sck  = 1'h0;
		cs_n = 1'h1;
	end

	// sck stands low between frames; 64 ns period only inside a frame
	task automatic frame_open(input logic [3:0] n);
		cs_n = 1'h0;
		#41;
		repeat (n) begin
			#32 sck = 1'h1;
			#32 sck = 1'h0;
		end
		#41;
	endtask : frame_open

	// long enough high time for the block to see the frame end
	task automatic frame_close;
		cs_n = 1'h1;
		#60;
	endtask : frame_close
endmodule : fesac_host_model

// ==== dv/testbench.sv ====
// self-checking bench for the flash error status and boot config bank
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================
	// signals and tables
	logic                           clk, reset, hsel, hwrite, hready, hreadyout, hresp;
	logic                           sck, cs_n, quad_enable;
	logic [1:0]                     htrans;
	logic [2:0]                     hsize, drive_strength, error_flags, ds;
	logic [31:0]                    haddr, hwdata, hrdata, q, ctl;
	fesac_pkg::fesac_cmd_event_type cmd_event;
	fesac_pkg::fesac_boot_type      boot;
	int                             fails, n_tests, starts, i;
	// outcome bits: fail prog, fail erase, protected, suspended, row lock, block hit,
	// password mismatch, status lock; expected flags are {erase, program, protection}
	logic [79:0]                    t_kind = 80'h1112_2344_5566_7899_9AA3;
	logic [159:0]                   t_bits = 160'h8020_1080_0800_0280_4080_0140_4080_4020_0804_2080;
	logic [79:0]                    t_exp  = 80'h2332_3332_4254_4245_5502;
	logic [27:0]                    t_n    = 28'h2378_568;
	logic [55:0]                    t_cfg  = 56'h6767_6161_6161_60;
	logic [6:0]                     t_act  = 7'h2A;
	logic [6:0]                     t_quad = 7'h06;

	assign hready = hreadyout;
	always #2 clk = ~clk;
	always @(posedge clk) if (boot.start === 1'h1) starts <= starts + 1;

	fesac_bank fesac_bank_inst (
		.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .cmd_event(cmd_event), .sck(sck), .cs_n(cs_n),
		.drive_strength(drive_strength), .error_flags(error_flags), .quad_enable(quad_enable),
		.boot(boot)
	);
	fesac_host_model fesac_host_model_inst (.sck(sck), .cs_n(cs_n));

	// ==========================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one single AHB-Lite transfer; read data taken at the edge ending the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		q = hrdata;
		// let the write land before the caller looks at any output
		#1;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'h0, a, 32'h0);
		check(what, q, exp);
		check("okay", {30'h0, hresp, hready}, 32'h1);
	endtask : rd

	task automatic ev(input logic [3:0] k, input logic [7:0] b, input logic [15:0] d);
		fesac_pkg::fesac_cmd_event_type e;
		e       = '0;
		e.valid = 1'h1;
		e.kind  = fesac_pkg::fesac_cmd_kind_type'(k);
		e.data  = d;
		{e.fail_program, e.fail_erase, e.target_protected, e.target_suspended,
			e.info_row_locked, e.block_protect_hit, e.pwd_mismatch, e.status_reg_locked} = b;
		@(posedge clk);
		cmd_event <= e;
		@(posedge clk);
		cmd_event <= '0;
		#1;
	endtask : ev

	task automatic complete_run;
		if (fails == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// ==========================================
	// sequence
	initial begin
		clk = 1'h0;
		reset = 1'h1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		cmd_event = '0;
		ctl = '0;
		fails = 0;
		n_tests = 0;
		starts = 0;
		repeat (10) @(posedge clk);
		reset <= 1'h0;
		for (i = 0; i < 20; i++) begin
			bus(1'h1, fesac_pkg::ADDR_CONTROL, 32'h1);
			ev(t_kind[79-4*i -: 4], t_bits[159-8*i -: 8], (i == 19) ? 16'h0006 : 16'h0000);
			check("flags", {29'h0, error_flags},
				{28'h0, t_exp[79-4*i -: 4]});
		end
		rd(fesac_pkg::ADDR_EXT_READ, 32'h0000_00E4, "ext read");
		// flags must neither block nor be touched by a good parameter set
		ev(4'h7, 8'h00, 16'h0020);
		check("drive", {29'h0, drive_strength}, 32'h1);
		check("held", {29'h0, error_flags}, 32'h2);
		ev(4'hB, 8'h00, 16'h0000);
		check("clear cmd", {29'h0, error_flags}, 32'h0);
		ev(4'h1, 8'h80, 16'h0000);
		ev(4'hC, 8'h00, 16'h0000);
		check("soft reset", {29'h0, error_flags}, 32'h0);
		ev(4'h1, 8'h80, 16'h0000);
		@(posedge clk);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		#1;
		check("hard reset", {26'h0, drive_strength, error_flags}, 32'h38);
		rd(fesac_pkg::ADDR_EXT_READ, 32'h0000_00E0, "ext reset");
		rd(fesac_pkg::ADDR_BOOT_CFG, 32'h0, "boot reset");
		rd(fesac_pkg::ADDR_PROT_CFG, 32'h0000_FFFF, "prot reset");
		ds = 3'h7;
		for (i = 0; i < 8; i++) begin
			bus(1'h1, fesac_pkg::ADDR_EXT_READ, {24'h0, i[2:0], 5'h0E});
			if (i != 0 && i != 4) ds = i[2:0];
			rd(fesac_pkg::ADDR_EXT_READ, {24'h0, ds, 5'h0}, "code");
			check("drive pin", {29'h0, drive_strength}, {29'h0, ds});
		end
		ev(4'h3, 8'h00, 16'h0004);
		ev(4'h3, 8'h00, 16'h0002);
		check("relock", {29'h0, error_flags}, 32'h3);
		ev(4'hB, 8'h00, 16'h0000);
		ev(4'h3, 8'h00, 16'h0006);
		rd(fesac_pkg::ADDR_PROT_CFG, 32'h0000_FFFD, "lock");
		ev(4'h8, 8'h00, 16'h000F);
		rd(fesac_pkg::ADDR_FUNC, 32'h0E, "func");
		ev(4'h8, 8'h00, 16'h00F0);
		ctl = 32'h4;
		bus(1'h1, fesac_pkg::ADDR_CONTROL, ctl);
		ev(4'h8, 8'h00, 16'h000E);
		bus(1'h1, fesac_pkg::ADDR_FUNC, 32'hFFFF_FFFF);
		bus(1'h1, 8'h40, 32'hFFFF_FFFF);
		rd(fesac_pkg::ADDR_FUNC, 32'hF0, "frozen");
		rd(8'h40, 32'h0, "unmapped");
		rd(fesac_pkg::ADDR_CONTROL, 32'h4, "control");
		check("quiet", {29'h0, error_flags}, 32'h0);
		for (i = 0; i < 7; i++) begin
			bus(1'h1, fesac_pkg::ADDR_BOOT_CFG, {24'h12_3456, t_cfg[55-8*i -: 8]});
			bus(1'h1, fesac_pkg::ADDR_CONTROL, {30'h0, t_quad[6-i], 1'h0});
			check("quad", {31'h0, quad_enable}, {31'h0, t_quad[6-i]});
			fesac_host_model_inst.frame_open(t_n[27-4*i -: 4]);
			check("boot", {31'h0, boot.active}, {31'h0, t_act[6-i]});
			if (t_act[6-i]) check("addr", boot.addr, 32'h1234_5660);
			fesac_host_model_inst.frame_close();
			check("boot end", {31'h0, boot.active}, 32'h0);
		end
		rd(fesac_pkg::ADDR_BOOT_CFG, 32'h1234_5660, "boot cfg");
		check("starts", starts, 32'h3);
		complete_run();
	end

	// the run takes under five microseconds; twenty times that means a hang
	initial begin
		#100000;
		fails++;
		complete_run();
	end
endmodule : testbench
